// [design/isp_flash_map.svh]
// Register offsets, field positions, reset values and timing counts of the flash control block.
`ifndef ISP_FLASH_MAP_SVH
`define ISP_FLASH_MAP_SVH

`define OFS_PROG_CTL       8'hBF
`define OFS_ADDR_LOW       8'hC4
`define OFS_ADDR_HIGH      8'hC5
`define OFS_DATA_BYTE      8'hC6
`define OFS_CMD_CTL        8'hC7
`define OFS_UNLOCK         8'hF6

`define CMD_BANK_BIT       6
`define CMD_OE_BIT         5
`define CMD_CE_BIT         4
`define CMD_FIELD_MSB      3
`define CMD_FIELD_LSB      0
`define CMD_ERASE          4'h2
`define CMD_PROGRAM        4'h1
`define CMD_READ           4'h0

`define CTL_REBOOT_BIT     7
`define CTL_AUX_RAM_BIT    4
`define CTL_BOOT_SEL_BIT   1
`define CTL_PROG_EN_BIT    0

`define RST_CMD_CTL        8'h00
`define RST_PROG_CTL       8'h00
`define RST_BYTE           8'h00
`define UNLOCK_KEY_FIRST   8'h87
`define UNLOCK_KEY_SECOND  8'h59
`define LOADER_ADDR_MASK   16'h0FFF
`define STRAP_SETTLE_CYC   2

`endif

// [design/isp_flash_pkg.sv]
// Types shared by the flash control block and its helpers.
package isp_flash_pkg;
  typedef enum logic { BANK_APPLICATION, BANK_LOADER } bank_t;
  typedef enum logic [1:0] { OP_NONE, OP_ERASE, OP_PROGRAM, OP_READ } op_kind_t;
  typedef enum logic [1:0] { LOCK_CLOSED, LOCK_HALF, LOCK_OPEN } unlock_state_t;
  typedef enum logic { ENG_IDLE, ENG_RUN } engine_state_t;
endpackage

// [design/boot_strap_sampler.sv]
// Synchronises the boot strap pins and captures the forced loader boot request after reset.
`timescale 1ns/1ps
`include "isp_flash_map.svh"
module boot_strap_sampler #(
  parameter int SETTLE_CYC = `STRAP_SETTLE_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic soft_rst_i,
  input  wire logic port2_7_i,
  input  wire logic port2_6_i,
  input  wire logic port4_3_i,
  output logic      strap_valid_o,
  output logic      forced_boot_o
);
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [3:0] settle_q;
  logic       done_q;

  // Two flops per pin; only the second stage feeds the capture logic.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= 3'h7;
      sync_q <= 3'h7;
    end else begin
      meta_q <= {port2_7_i, port2_6_i, port4_3_i};
      sync_q <= meta_q;
    end
  end

  // Wait until the synchroniser holds post-reset levels, then latch once.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      settle_q      <= 4'h0;
      done_q        <= 1'b0;
      strap_valid_o <= 1'b0;
      forced_boot_o <= 1'b0;
    end else if (soft_rst_i) begin
      settle_q      <= 4'h0;
      done_q        <= 1'b0;
      strap_valid_o <= 1'b0;
      forced_boot_o <= 1'b0;
    end else begin
      strap_valid_o <= 1'b0;
      if (!done_q) begin
        if (settle_q == 4'(SETTLE_CYC)) begin
          done_q        <= 1'b1;
          strap_valid_o <= 1'b1;
          forced_boot_o <= (!sync_q[2] && !sync_q[1]) || !sync_q[0];
        end else begin
          settle_q <= settle_q + 4'h1;
        end
      end
    end
  end
endmodule // boot_strap_sampler

// [design/flash_op_engine.sv]
// Drives one erase, program or read on the flash array and waits for its completion.
`timescale 1ns/1ps
`include "isp_flash_map.svh"
module flash_op_engine #(
  parameter int ADDR_W = 16
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   soft_rst_i,
  input  wire logic                   start_i,
  input  isp_flash_pkg::op_kind_t     kind_i,
  input  isp_flash_pkg::bank_t        bank_i,
  input  wire logic [ADDR_W-1:0]      addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   flash_done_i,
  input  wire logic [7:0]             flash_rdata_i,
  output logic                        busy_o,
  output logic                        read_done_o,
  output logic [7:0]                  read_data_o,
  output logic                        flash_bank_o,
  output logic [ADDR_W-1:0]           flash_addr_o,
  output logic [7:0]                  flash_wdata_o,
  output logic                        flash_erase_o,
  output logic                        flash_program_o,
  output logic                        flash_read_o
);
  isp_flash_pkg::engine_state_t state_q;

  // Strobes hold until the array reports completion; a soft reboot aborts.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q         <= isp_flash_pkg::ENG_IDLE;
      busy_o          <= 1'b0;
      read_done_o     <= 1'b0;
      read_data_o     <= `RST_BYTE;
      flash_bank_o    <= 1'b0;
      flash_addr_o    <= '0;
      flash_wdata_o   <= `RST_BYTE;
      flash_erase_o   <= 1'b0;
      flash_program_o <= 1'b0;
      flash_read_o    <= 1'b0;
    end else if (soft_rst_i) begin
      state_q         <= isp_flash_pkg::ENG_IDLE;
      busy_o          <= 1'b0;
      read_done_o     <= 1'b0;
      flash_erase_o   <= 1'b0;
      flash_program_o <= 1'b0;
      flash_read_o    <= 1'b0;
    end else begin
      read_done_o <= 1'b0;
      case (state_q)
        isp_flash_pkg::ENG_IDLE: begin
          if (start_i && kind_i != isp_flash_pkg::OP_NONE) begin
            state_q         <= isp_flash_pkg::ENG_RUN;
            busy_o          <= 1'b1;
            flash_bank_o    <= (bank_i == isp_flash_pkg::BANK_LOADER);
            flash_addr_o    <= addr_i;
            flash_wdata_o   <= wdata_i;
            flash_erase_o   <= (kind_i == isp_flash_pkg::OP_ERASE);
            flash_program_o <= (kind_i == isp_flash_pkg::OP_PROGRAM);
            flash_read_o    <= (kind_i == isp_flash_pkg::OP_READ);
          end
        end
        isp_flash_pkg::ENG_RUN: begin
          if (flash_done_i) begin
            state_q         <= isp_flash_pkg::ENG_IDLE;
            busy_o          <= 1'b0;
            read_done_o     <= flash_read_o;
            read_data_o     <= flash_rdata_i;
            flash_erase_o   <= 1'b0;
            flash_program_o <= 1'b0;
            flash_read_o    <= 1'b0;
          end
        end
        default: state_q <= isp_flash_pkg::ENG_IDLE;
      endcase
    end
  end
endmodule // flash_op_engine

// [design/isp_flash_control.sv]
// In-system programming control: command and control registers, boot selection, flash sequencing.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "isp_flash_map.svh"
module isp_flash_control #(
  parameter int ADDR_W        = 16,
  parameter int STRAP_SETTLE  = `STRAP_SETTLE_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic [7:0]             reg_rdata_o,
  input  wire logic              cpu_idle_i,
  input  wire logic              port2_7_i,
  input  wire logic              port2_6_i,
  input  wire logic              port4_3_i,
  input  wire logic              flash_done_i,
  input  wire logic [7:0]        flash_rdata_i,
  output logic                   flash_bank_o,
  output logic [ADDR_W-1:0]      flash_addr_o,
  output logic [7:0]             flash_wdata_o,
  output logic                   flash_erase_o,
  output logic                   flash_program_o,
  output logic                   flash_read_o,
  output logic                   op_busy_o,
  output logic                   aux_ram_enable_o,
  output logic                   isp_mode_o,
  output logic                   exec_bank_o,
  output logic                   pc_clear_o,
  output logic                   sys_reset_o
);
  // Maps the command field and the two enables onto an operation; any other mix does nothing.
  function automatic isp_flash_pkg::op_kind_t decode_op(input logic [7:0] cmd);
    logic [3:0] field;
    field = cmd[`CMD_FIELD_MSB:`CMD_FIELD_LSB];
    decode_op = isp_flash_pkg::OP_NONE;
    if (!cmd[`CMD_CE_BIT]) begin
      if (field == `CMD_ERASE && cmd[`CMD_OE_BIT]) begin
        decode_op = isp_flash_pkg::OP_ERASE;
      end else if (field == `CMD_PROGRAM && cmd[`CMD_OE_BIT]) begin
        decode_op = isp_flash_pkg::OP_PROGRAM;
      end else if (field == `CMD_READ && !cmd[`CMD_OE_BIT]) begin
        decode_op = isp_flash_pkg::OP_READ;
      end
    end
  endfunction

  logic [6:0]                   cmd_q;
  logic                         aux_q;
  logic                         boot_sel_q;
  logic                         prog_en_q;
  logic [7:0]                   addr_hi_q;
  logic [7:0]                   addr_lo_q;
  logic [7:0]                   data_q;
  isp_flash_pkg::unlock_state_t lock_q;
  logic                         pending_q;
  logic                         idle_prev_q;
  logic                         forced_q;
  isp_flash_pkg::bank_t         exec_bank_q;
  logic                         soft_rst_q;
  logic                         strap_valid;
  logic                         strap_forced;
  logic                         eng_busy;
  logic                         eng_read_done;
  logic [7:0]                   eng_read_data;
  logic                         wr_ctl;
  logic                         wr_cmd;
  logic                         start_op;
  logic                         wake;
  isp_flash_pkg::op_kind_t      op_kind;
  isp_flash_pkg::bank_t         op_bank;
  logic [15:0]                  op_addr;

  // Write decode and operation launch conditions.
  assign wr_ctl   = reg_wr_i && reg_addr_i == `OFS_PROG_CTL && lock_q == isp_flash_pkg::LOCK_OPEN;
  assign wr_cmd   = reg_wr_i && reg_addr_i == `OFS_CMD_CTL;
  assign op_kind  = decode_op({1'b0, cmd_q});
  assign op_bank  = cmd_q[`CMD_BANK_BIT] ? isp_flash_pkg::BANK_LOADER
                                         : isp_flash_pkg::BANK_APPLICATION;
  // The loader bank is only 4K deep, so its upper address bits are dropped.
  assign op_addr  = (op_bank == isp_flash_pkg::BANK_LOADER) ?
                    ({addr_hi_q, addr_lo_q} & `LOADER_ADDR_MASK) : {addr_hi_q, addr_lo_q};
  assign start_op = pending_q && cpu_idle_i && prog_en_q && !eng_busy;
  assign wake     = idle_prev_q && !cpu_idle_i;

  // Software reboot: one-cycle pulse that restarts the control state like a power-on; the engine keeps its bank, address, write and read data outputs.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_ctl && !soft_rst_q && reg_wdata_i[`CTL_REBOOT_BIT]
                    && reg_wdata_i[`CTL_BOOT_SEL_BIT] && reg_wdata_i[`CTL_PROG_EN_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sys_reset_o <= 1'b0;
    end else begin
      sys_reset_o <= soft_rst_q;
    end
  end

  // Unlock sequence; any other value written to the unlock offset closes it again, except a repeated first key, which keeps it half open.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_q <= isp_flash_pkg::LOCK_CLOSED;
    end else if (soft_rst_q) begin
      lock_q <= isp_flash_pkg::LOCK_CLOSED;
    end else if (reg_wr_i && reg_addr_i == `OFS_UNLOCK) begin
      case (lock_q)
        isp_flash_pkg::LOCK_CLOSED:
          lock_q <= (reg_wdata_i == `UNLOCK_KEY_FIRST) ? isp_flash_pkg::LOCK_HALF
                                                       : isp_flash_pkg::LOCK_CLOSED;
        isp_flash_pkg::LOCK_HALF:
          lock_q <= (reg_wdata_i == `UNLOCK_KEY_SECOND) ? isp_flash_pkg::LOCK_OPEN
                    : (reg_wdata_i == `UNLOCK_KEY_FIRST) ? isp_flash_pkg::LOCK_HALF
                    : isp_flash_pkg::LOCK_CLOSED;
        default:
          lock_q <= isp_flash_pkg::LOCK_CLOSED;
      endcase
    end
  end

  // Programming control fields; only the unlocked path may change them.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aux_q      <= 1'b0;
      boot_sel_q <= 1'b0;
      prog_en_q  <= 1'b0;
    end else if (soft_rst_q) begin
      aux_q      <= 1'b0;
      boot_sel_q <= 1'b0;
      prog_en_q  <= 1'b0;
    end else if (wr_ctl) begin
      aux_q      <= reg_wdata_i[`CTL_AUX_RAM_BIT];
      boot_sel_q <= reg_wdata_i[`CTL_BOOT_SEL_BIT];
      prog_en_q  <= reg_wdata_i[`CTL_PROG_EN_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aux_ram_enable_o <= 1'b0;
    end else begin
      aux_ram_enable_o <= aux_q;
    end
  end

  // Command byte: a write of a valid command arms one operation for the next idle period; any other write arms nothing.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_q     <= 7'(`RST_CMD_CTL);
      pending_q <= 1'b0;
    end else if (soft_rst_q) begin
      cmd_q     <= 7'(`RST_CMD_CTL);
      pending_q <= 1'b0;
    end else if (wr_cmd) begin
      cmd_q     <= reg_wdata_i[6:0];
      pending_q <= 1'b1;
    end else if (start_op || (pending_q && op_kind == isp_flash_pkg::OP_NONE)) begin
      pending_q <= 1'b0;
    end
  end

  // Address and data bytes; a finished read overwrites data and wins over a write.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_hi_q <= `RST_BYTE;
      addr_lo_q <= `RST_BYTE;
      data_q    <= `RST_BYTE;
    end else if (soft_rst_q) begin
      addr_hi_q <= `RST_BYTE;
      addr_lo_q <= `RST_BYTE;
      data_q    <= `RST_BYTE;
    end else begin
      if (reg_wr_i && reg_addr_i == `OFS_ADDR_HIGH) begin
        addr_hi_q <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `OFS_ADDR_LOW) begin
        addr_lo_q <= reg_wdata_i;
      end
      if (eng_read_done) begin
        data_q <= eng_read_data;
      end else if (reg_wr_i && reg_addr_i == `OFS_DATA_BYTE) begin
        data_q <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_prev_q <= 1'b0;
    end else begin
      idle_prev_q <= cpu_idle_i;
    end
  end

  // Execution bank, programming mode and program counter clear.
  // Straps are only trusted once the sampler reports valid levels.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      exec_bank_q <= isp_flash_pkg::BANK_APPLICATION;
      forced_q    <= 1'b0;
      isp_mode_o  <= 1'b0;
      pc_clear_o  <= 1'b0;
    end else if (soft_rst_q) begin
      exec_bank_q <= isp_flash_pkg::BANK_APPLICATION;
      forced_q    <= 1'b0;
      isp_mode_o  <= 1'b0;
      pc_clear_o  <= 1'b0;
    end else begin
      pc_clear_o <= 1'b0;
      if (strap_valid && strap_forced) begin
        forced_q    <= 1'b1;
        exec_bank_q <= isp_flash_pkg::BANK_LOADER;
      end else if (wake && prog_en_q && !isp_mode_o) begin
        isp_mode_o <= 1'b1;
        if (boot_sel_q) begin
          exec_bank_q <= isp_flash_pkg::BANK_LOADER;
          pc_clear_o  <= (exec_bank_q == isp_flash_pkg::BANK_APPLICATION);
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      exec_bank_o <= 1'b0;
    end else begin
      exec_bank_o <= (exec_bank_q == isp_flash_pkg::BANK_LOADER);
    end
  end

  // Register reads: data stand for exactly one cycle; unmapped or reserved bits read zero.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= `RST_BYTE;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `OFS_PROG_CTL:  reg_rdata_o <= {forced_q, 2'b00, aux_q, 2'b00, boot_sel_q, prog_en_q};
        `OFS_CMD_CTL:   reg_rdata_o <= {1'b0, cmd_q};
        `OFS_ADDR_HIGH: reg_rdata_o <= addr_hi_q;
        `OFS_ADDR_LOW:  reg_rdata_o <= addr_lo_q;
        `OFS_DATA_BYTE: reg_rdata_o <= data_q;
        default:        reg_rdata_o <= `RST_BYTE;
      endcase
    end else begin
      reg_rdata_o <= `RST_BYTE;
    end
  end

  boot_strap_sampler #(
    .SETTLE_CYC    (STRAP_SETTLE)
  ) u_straps (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .soft_rst_i    (soft_rst_q),
    .port2_7_i     (port2_7_i),
    .port2_6_i     (port2_6_i),
    .port4_3_i     (port4_3_i),
    .strap_valid_o (strap_valid),
    .forced_boot_o (strap_forced)
  );

  flash_op_engine #(
    .ADDR_W          (ADDR_W)
  ) u_engine (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .soft_rst_i      (soft_rst_q),
    .start_i         (start_op),
    .kind_i          (op_kind),
    .bank_i          (op_bank),
    .addr_i          (op_addr[ADDR_W-1:0]),
    .wdata_i         (data_q),
    .flash_done_i    (flash_done_i),
    .flash_rdata_i   (flash_rdata_i),
    .busy_o          (eng_busy),
    .read_done_o     (eng_read_done),
    .read_data_o     (eng_read_data),
    .flash_bank_o    (flash_bank_o),
    .flash_addr_o    (flash_addr_o),
    .flash_wdata_o   (flash_wdata_o),
    .flash_erase_o   (flash_erase_o),
    .flash_program_o (flash_program_o),
    .flash_read_o    (flash_read_o)
  );

  assign op_busy_o = eng_busy;
endmodule // isp_flash_control

// [tb/isp_flash_control_assertions.sv]
// Port-level checker for the flash control block and its bind.
`timescale 1ns/1ps
module isp_flash_control_checker #(
  parameter int ADDR_W = 16
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic [7:0]        reg_addr_i,
  input wire logic              reg_rd_i,
  input wire logic [7:0]        reg_rdata_o,
  input wire logic              cpu_idle_i,
  input wire logic              flash_done_i,
  input wire logic              flash_bank_o,
  input wire logic [ADDR_W-1:0] flash_addr_o,
  input wire logic [7:0]        flash_wdata_o,
  input wire logic              flash_erase_o,
  input wire logic              flash_program_o,
  input wire logic              flash_read_o,
  input wire logic              op_busy_o,
  input wire logic              aux_ram_enable_o,
  input wire logic              isp_mode_o,
  input wire logic              exec_bank_o,
  input wire logic              pc_clear_o,
  input wire logic              sys_reset_o
);
  logic any_op;

  // Any of the three array strobes; the engine runs one at a time.
  assign any_op = flash_erase_o | flash_program_o | flash_read_o;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Steps of an operation's end, of the switch into the loader bank and of the cleared state after a reboot.
  sequence s_released;
    !any_op && !op_busy_o;
  endsequence
  sequence s_loader_soon;
    ##[0:2] exec_bank_o;
  endsequence
  sequence s_cleared;
    !isp_mode_o && !aux_ram_enable_o && !op_busy_o;
  endsequence

  property p_rdata_quiet;
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
  endproperty
  property p_ctl_reserved;
    reg_rd_i && reg_addr_i == 8'hBF |=> (reg_rdata_o & 8'h6C) == 8'h00;
  endproperty
  property p_cmd_top_bit;
    reg_rd_i && reg_addr_i == 8'hC7 |=> !reg_rdata_o[7];
  endproperty
  property p_one_op;
    $onehot0({flash_erase_o, flash_program_o, flash_read_o});
  endproperty
  property p_op_busy;
    any_op |-> op_busy_o;
  endproperty
  property p_start_idle;
    $rose(any_op) |-> $past(cpu_idle_i);
  endproperty
  property p_hold;
    any_op && !flash_done_i |=> any_op && $stable(flash_bank_o) && $stable(flash_addr_o)
      && $stable(flash_wdata_o);
  endproperty
  property p_finish;
    any_op && flash_done_i |=> s_released;
  endproperty
  property p_loader_mask;
    any_op && flash_bank_o |-> (flash_addr_o >> 12) == '0;
  endproperty
  property p_isp_wake;
    $rose(isp_mode_o) |-> $past(cpu_idle_i, 2) && !$past(cpu_idle_i);
  endproperty
  property p_pc_clear;
    pc_clear_o |-> s_loader_soon;
  endproperty
  property p_reboot;
    sys_reset_o |=> !sys_reset_o ##2 s_cleared;
  endproperty

  a_rdata_quiet:  assert property (p_rdata_quiet)  else $error("read data outside slot");
  a_ctl_reserved: assert property (p_ctl_reserved) else $error("reserved bits read 1");
  a_cmd_top_bit:  assert property (p_cmd_top_bit)  else $error("command bit 7 read 1");
  a_one_op:       assert property (p_one_op)       else $error("two strobes at once");
  a_op_busy:      assert property (p_op_busy)      else $error("strobe without busy");
  a_start_idle:   assert property (p_start_idle)   else $error("start outside idle");
  a_hold:         assert property (p_hold)         else $error("operation not held");
  a_finish:       assert property (p_finish)       else $error("operation not ended");
  a_loader_mask:  assert property (p_loader_mask)  else $error("loader address wide");
  a_isp_wake:     assert property (p_isp_wake)     else $error("mode without wake");
  a_pc_clear:     assert property (p_pc_clear)     else $error("clear without loader");
  a_reboot:       assert property (p_reboot)       else $error("reboot left state");
endmodule // isp_flash_control_checker

bind isp_flash_control isp_flash_control_checker #(.ADDR_W(ADDR_W)) checker_i (
  .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .cpu_idle_i(cpu_idle_i), .flash_done_i(flash_done_i),
  .flash_bank_o(flash_bank_o), .flash_addr_o(flash_addr_o), .flash_wdata_o(flash_wdata_o),
  .flash_erase_o(flash_erase_o), .flash_program_o(flash_program_o),
  .flash_read_o(flash_read_o), .op_busy_o(op_busy_o), .aux_ram_enable_o(aux_ram_enable_o),
  .isp_mode_o(isp_mode_o), .exec_bank_o(exec_bank_o), .pc_clear_o(pc_clear_o),
  .sys_reset_o(sys_reset_o));

// [tb/testbench.sv]
// Self-checking bench for the flash control block.
`timescale 1ns/1ps
`include "isp_flash_map.svh"
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        cpu_idle_i = 1'b0;
  logic        port2_7_i = 1'b1;
  logic        port2_6_i = 1'b1;
  logic        port4_3_i = 1'b1;
  logic        flash_done_i = 1'b0;
  logic [7:0]  flash_rdata_i = 8'h00;
  logic [7:0]  reg_rdata_o;
  logic [15:0] flash_addr_o;
  logic [7:0]  flash_wdata_o;
  logic        flash_bank_o, flash_erase_o, flash_program_o, flash_read_o, op_busy_o;
  logic        aux_ram_enable_o, isp_mode_o, exec_bank_o, pc_clear_o, sys_reset_o;
  logic        any_op;
  int          n_pc = 0;
  int          n_rb = 0;
  int          n_fail = 0;
  int          checked = 0;

  isp_flash_control #(.ADDR_W(16), .STRAP_SETTLE(2)) isp_flash_control_i (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .cpu_idle_i(cpu_idle_i), .port2_7_i(port2_7_i), .port2_6_i(port2_6_i),
    .port4_3_i(port4_3_i), .flash_done_i(flash_done_i), .flash_rdata_i(flash_rdata_i),
    .flash_bank_o(flash_bank_o), .flash_addr_o(flash_addr_o), .flash_wdata_o(flash_wdata_o),
    .flash_erase_o(flash_erase_o), .flash_program_o(flash_program_o),
    .flash_read_o(flash_read_o), .op_busy_o(op_busy_o), .aux_ram_enable_o(aux_ram_enable_o),
    .isp_mode_o(isp_mode_o), .exec_bank_o(exec_bank_o), .pc_clear_o(pc_clear_o),
    .sys_reset_o(sys_reset_o));

  // Clock of 20 ns and the combined strobe view.
  always #10 clk_i = ~clk_i;
  assign any_op = flash_erase_o | flash_program_o | flash_read_o;

  // One-cycle pulses are counted here so a scenario cannot miss them between polls.
  always @(posedge clk_i) begin
    if (pc_clear_o === 1'b1) n_pc <= n_pc + 1;
    if (sys_reset_o === 1'b1) n_rb <= n_rb + 1;
  end

  task automatic close_out;
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  // The read byte stands only in the cycle after the strobe, so it is taken just past that edge.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask

  task automatic wait_op(input int lim);
    int n;
    for (n = 0; n < lim && any_op !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    if (n == lim) begin
      n_fail++;
      close_out;
    end
  endtask

  // Waits for the strobe, checks what it carries, then completes it like the array would.
  task automatic run_op(input logic [7:0] cmd, input int k, input logic [7:0] rb);
    wait_op(20);
    chk({flash_erase_o, flash_program_o, flash_read_o}, 3'b100 >> k);
    chk(flash_bank_o, cmd[6]);
    if (k != 0) chk(flash_addr_o, cmd[6] ? 16'h0234 : 16'h1234);
    if (k == 1) chk(flash_wdata_o, 8'hA5);
    @(posedge clk_i);
    flash_done_i  <= 1'b1;
    flash_rdata_i <= rb;
    @(posedge clk_i);
    flash_done_i  <= 1'b0;
    @(posedge clk_i);
    #1;
    chk({any_op, op_busy_o}, 2'b00);
    if (k == 2) rd_chk(`OFS_DATA_BYTE, rb);
  endtask

  task automatic t_reset_vals;
    chk(exec_bank_o, 1'b0);
    rd_chk(`OFS_PROG_CTL, 8'h00);
    wr(`OFS_CMD_CTL, 8'hB5);
    rd_chk(`OFS_CMD_CTL, 8'h35);
    rd_chk(8'h80, 8'h00);
  endtask

  task automatic t_lock;
    wr(`OFS_PROG_CTL, 8'h10);
    rd_chk(`OFS_PROG_CTL, 8'h00);
    wr(`OFS_UNLOCK, 8'h87);
    wr(`OFS_UNLOCK, 8'h59);
    wr(`OFS_PROG_CTL, 8'h70);
    rd_chk(`OFS_PROG_CTL, 8'h10);
    chk(aux_ram_enable_o, 1'b1);
    wr(`OFS_PROG_CTL, 8'h00);
    rd_chk(`OFS_PROG_CTL, 8'h00);
    chk(aux_ram_enable_o, 1'b0);
    wr(`OFS_UNLOCK, 8'h00);
    wr(`OFS_PROG_CTL, 8'h10);
    rd_chk(`OFS_PROG_CTL, 8'h00);
    wr(`OFS_UNLOCK, 8'h87);
    wr(`OFS_UNLOCK, 8'h59);
  endtask

  // A command armed while the CPU runs must wait for idle; then every bank and command.
  task automatic t_ops;
    logic [7:0] base [3];
    logic [7:0] cmd;
    base = '{8'h22, 8'h21, 8'h00};
    wr(`OFS_PROG_CTL, 8'h01);
    wr(`OFS_ADDR_HIGH, 8'h12);
    wr(`OFS_ADDR_LOW, 8'h34);
    wr(`OFS_DATA_BYTE, 8'hA5);
    wr(`OFS_CMD_CTL, 8'h00);
    repeat (5) @(posedge clk_i);
    #1;
    chk(any_op, 1'b0);
    @(posedge clk_i);
    cpu_idle_i <= 1'b1;
    run_op(8'h00, 2, 8'h3C);
    wr(`OFS_CMD_CTL, 8'h02);
    repeat (4) @(posedge clk_i);
    #1;
    chk(any_op, 1'b0);
    for (int b = 0; b < 2; b++) begin
      for (int k = 0; k < 3; k++) begin
        cmd = base[k] | (b != 0 ? 8'h40 : 8'h00);
        wr(`OFS_DATA_BYTE, 8'hA5);
        wr(`OFS_CMD_CTL, cmd);
        run_op(cmd, k, 8'h5A ^ 8'(b));
      end
    end
  endtask

  task automatic t_boot;
    int pc0;
    int rb0;
    pc0 = n_pc;
    rb0 = n_rb;
    wr(`OFS_PROG_CTL, 8'h03);
    @(posedge clk_i);
    cpu_idle_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    chk({isp_mode_o, exec_bank_o}, 2'b11);
    chk(16'(n_pc - pc0), 16'h0001);
    wr(`OFS_PROG_CTL, 8'h81);
    repeat (4) @(posedge clk_i);
    #1;
    chk(16'(n_rb - rb0), 16'h0000);
    wr(`OFS_PROG_CTL, 8'h83);
    repeat (4) @(posedge clk_i);
    #1;
    chk(16'(n_rb - rb0), 16'h0001);
    chk({isp_mode_o, exec_bank_o}, 2'b00);
    rd_chk(`OFS_PROG_CTL, 8'h00);
    wr(`OFS_CMD_CTL, 8'h00);
    cpu_idle_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    chk(any_op, 1'b0);
  endtask

  // Strap sets: both port 2 pins low, port 4 pin low, and one port 2 pin low alone.
  task automatic t_strap;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      rst_i     <= 1'b1;
      port2_7_i <= i == 1;
      port2_6_i <= i != 0;
      port4_3_i <= i != 1;
      repeat (2) @(posedge clk_i);
      rst_i     <= 1'b0;
      repeat (8) @(posedge clk_i);
      #1;
      chk(exec_bank_o, i != 2);
      rd_chk(`OFS_PROG_CTL, i != 2 ? 8'h80 : 8'h00);
    end
  endtask

  // Main sequence after 20 cycles of reset.
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_vals;
    t_lock;
    t_ops;
    t_boot;
    t_strap;
    close_out;
  end
endmodule // testbench
